// *** inc/rcs_pkg.sv ***
// reset cause tracking: register map, fields, timing and state types
package rcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the local register port
  localparam logic [1:0] RCS_OFF_CAUSE = 2'h0;
  localparam logic [1:0] RCS_OFF_CAUSE_TWO = 2'h1;
  localparam logic [1:0] RCS_OFF_SUPPLY = 2'h2;
  localparam logic [1:0] RCS_OFF_SLEEP = 2'h3;

  // reset_cause_control fields
  localparam int RCS_IRQ_PRIO_BIT = 7;
  localparam int RCS_MISMATCH_BIT = 5;
  localparam int RCS_RESET_INSTR_BIT = 4;
  localparam int RCS_WDT_TIMEOUT_BIT = 3;
  localparam int RCS_POWER_DOWN_BIT = 2;
  localparam int RCS_POWER_ON_BIT = 1;
  localparam int RCS_BROWNOUT_BIT = 0;
  // reset_cause_control_two fields
  localparam int RCS_MASTER_CLEAR_BIT = 7;
  localparam int RCS_SW_WDT_EN_BIT = 5;
  // supply_reset_flags fields
  localparam int RCS_SUPPLY_BROWNOUT_BIT = 3;
  localparam int RCS_SUPPLY_POWER_ON_BIT = 2;
  localparam int RCS_BATTERY_POWER_ON_BIT = 1;
  localparam int RCS_BATTERY_MODE_BIT = 0;
  // sleep_power_control fields
  localparam int RCS_RETENTION_SEL_BIT = 4;
  localparam int RCS_DEEP_SLEEP_WAKE_BIT = 2;
  localparam int RCS_PM_SLEEP_BIAS_BIT = 0;

  // write masks (plain read/write) and clear-only masks per register
  localparam logic [7:0] RCS_CAUSE_WMASK = 8'hB3;
  localparam logic [7:0] RCS_CAUSE_TWO_WMASK = 8'h20;
  localparam logic [7:0] RCS_CAUSE_TWO_CMASK = 8'h80;
  localparam logic [7:0] RCS_SUPPLY_WMASK = 8'h01;
  localparam logic [7:0] RCS_SUPPLY_CMASK = 8'h0E;
  localparam logic [7:0] RCS_SLEEP_WMASK = 8'h11;
  localparam logic [7:0] RCS_SLEEP_CMASK = 8'h04;

  // reset values
  localparam logic [7:0] RCS_CAUSE_RST = 8'h3C;
  localparam logic [7:0] RCS_CAUSE_TWO_RST = 8'h00;
  localparam logic [7:0] RCS_SUPPLY_RST = 8'h00;
  localparam logic [7:0] RCS_SLEEP_RST = 8'h00;

  // watchdog configuration code under which the software enable counts
  localparam logic [1:0] RCS_WDT_SW_MODE = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // timing, clock 20 MHz; least times round up
  localparam int RCS_CLK_NS = 50;
  localparam int RCS_BIAS_SETTLE_NS = 500;
  localparam int RCS_BIAS_CYC = (RCS_BIAS_SETTLE_NS + RCS_CLK_NS - 1) /
                                RCS_CLK_NS;
  localparam int RCS_PWRT_US = 1000;
  localparam int RCS_PWRT_CYC = (RCS_PWRT_US * 1000 + RCS_CLK_NS - 1) /
                                RCS_CLK_NS;
  localparam int RCS_OSC_START_US = 100;
  localparam int RCS_OSC_CYC = (RCS_OSC_START_US * 1000 + RCS_CLK_NS - 1) /
                               RCS_CLK_NS;
  localparam int RCS_HOLD_NS = 1000;
  localparam int RCS_HOLD_CYC = (RCS_HOLD_NS + RCS_CLK_NS - 1) / RCS_CLK_NS;

  // index of each reset cause in the one-hot cause vector
  localparam int RCS_CAUSE_POWER_ON = 0;
  localparam int RCS_CAUSE_MASTER_CLEAR = 1;
  localparam int RCS_CAUSE_WATCHDOG = 2;
  localparam int RCS_CAUSE_MISMATCH = 3;
  localparam int RCS_CAUSE_BROWNOUT = 4;
  localparam int RCS_CAUSE_INSTR = 5;
  localparam int RCS_CAUSE_STACK = 6;

  ////////////////////////////////////////////////////////////////////////////
  // power sequencer states
  typedef enum logic [4:0] {
    RCS_SQ_RUN = 5'b00001,
    RCS_SQ_BIAS = 5'b00010,
    RCS_SQ_PWRT = 5'b00100,
    RCS_SQ_OSC = 5'b01000,
    RCS_SQ_HOLD = 5'b10000
  } rcs_seq_t;

  // asynchronous supply monitor levels from the analog side
  typedef struct packed {
    logic core_ok;
    logic core_below_start;
    logic battery_ok;
    logic battery_below_start;
    logic battery_present;
    logic brownout_trip;
    logic supply_brownout_trip;
  } rcs_supply_t;

  // one-cycle events from core logic on clk
  typedef struct packed {
    logic wdt_timeout;
    logic config_mismatch;
    logic reset_instr;
    logic stack_error;
    logic clear_watchdog_instruction;
    logic sleep_instr;
    logic deep_sleep_wake;
  } rcs_core_ev_t;

  // one power-on monitor
  typedef struct packed {
    logic armed;
    logic hibernate;
    logic pulse;
  } rcs_mon_t;

  // all state of the top module except the system reset flop
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] reset_cause_control;
    logic [7:0] reset_cause_control_two;
    logic [7:0] supply_reset_flags;
    logic [7:0] sleep_power_control;
    rcs_mon_t core_mon;
    rcs_mon_t battery_mon;
    logic first_power_on;
    rcs_seq_t seq;
    logic [15:0] cnt;
    logic [6:0] last_cause;
    logic [7:0] rd_data;
    logic release_ok;
    logic wdt_on;
    logic retention_mode;
    logic pm_bias_on;
  } rcs_state_t;

  // pin stages start at the idle high level so no false pin reset follows
  localparam rcs_state_t RCS_STATE_RST = '{
    sync1: 8'h01,
    sync2: 8'h01,
    reset_cause_control: RCS_CAUSE_RST,
    reset_cause_control_two: RCS_CAUSE_TWO_RST,
    supply_reset_flags: RCS_SUPPLY_RST,
    sleep_power_control: RCS_SLEEP_RST,
    core_mon: '{armed: 1'b1, hibernate: 1'b0, pulse: 1'b0},
    battery_mon: '{armed: 1'b1, hibernate: 1'b0, pulse: 1'b0},
    seq: RCS_SQ_BIAS,
    last_cause: 7'h01,
    default: '0
  };

endpackage : rcs_pkg

// *** logic/rcs_reset_cause.sv ***
// reset cause flags, power-on sequencer and reset control registers
//
// How it works
// - seven reset causes tracked; last cause kept one-hot on an output
// - software writes to status flags only store; they never start a reset
// - bit 7 of the first register enables interrupt priority; resets to 0
// - mismatch reset clears bit 5; software writes 1 to re-arm
// - reset instruction clears bit 4; only software sets it again
// - watchdog flag set by power-up, watchdog clear or sleep; cleared by timeout
// - power-down flag set by power-up or watchdog clear; cleared by sleep
// - power-on flag cleared by power-on reset; set only by software
// - brown-out flag cleared by brown-out reset; set only by software
// - master clear reset sets bit 7 of second register; software clears
// - software watchdog enable acts only when configuration field is 10
// - supply brown-out flag set only by hardware; software only clears
// - supply power-on flag set by hardware; software only clears
// - battery power-on flag set on battery reset and original power-up
// - battery mode flag set on power-on exit with battery pin powered
// - retention sleep needs select 1, config 0, regulator on; else bias bit
// - deep-sleep wake flag set by hardware; software only clears
// - program memory bias kept in sleep when 1, powered down when 0
// - power-on pulse on supply rise; re-armed only after supply falls low
// - core and battery monitors each hibernate after their power-on event
// - power-on holds reset for bias settle, power-up timer, clock start
// - master clear low asserts reset asynchronously; release restarts core
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module rcs_reset_cause #(
  parameter int PWRT_CYC = rcs_pkg::RCS_PWRT_CYC
) (
  // clock, reset and clock enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // pins and supply monitors, asynchronous
  input wire logic master_clear_pin_b,
  input wire rcs_pkg::rcs_supply_t supply,
  // core events and configuration on clk
  input wire rcs_pkg::rcs_core_ev_t core_ev,
  input wire logic [1:0] watchdog_config_field,
  input wire logic retention_config_bit,
  input wire logic regulator_en,
  // control outputs
  output logic interrupt_priority_enable,
  output logic watchdog_enable,
  output logic retention_sleep_mode,
  output logic pm_bias_sleep_on,
  output logic system_reset_signal_b,
  output logic core_hibernate,
  output logic battery_hibernate,
  output logic [6:0] reset_cause
);
  import rcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // merge a software write: plain bits take data, clear-only bits clear
  // where a zero is written, every other bit keeps its stored value
  function automatic logic [7:0] wr_merge(logic [7:0] old, logic [7:0] wd,
                                          logic [7:0] wmask,
                                          logic [7:0] cmask);
    wr_merge = (old & ~(wmask | cmask)) | (wd & wmask) | (old & wd & cmask);
  endfunction : wr_merge

  // power-on monitor step: fire once, hibernate, re-arm on a low supply
  function automatic rcs_mon_t mon_step(rcs_mon_t m, logic ok, logic low);
    rcs_mon_t r;
    r = m;
    r.pulse = 1'b0;
    if (low) begin
      r.armed = 1'b1;
      r.hibernate = 1'b0;
    end else if (m.armed && ok) begin
      r.armed = 1'b0;
      r.hibernate = 1'b1;
      r.pulse = 1'b1;
    end
    mon_step = r;
  endfunction : mon_step

  // last count of a delay stage
  function automatic logic cnt_done(logic [15:0] c, int lim);
    cnt_done = (c == 16'(lim - 1));
  endfunction : cnt_done

  ////////////////////////////////////////////////////////////////////////////
  // state

  rcs_state_t s_q;
  rcs_state_t s_d;
  logic sys_reset_b_q;
  logic hold_b;

  // synchronised pin levels, read from the second stage only
  logic master_clear_b;
  logic core_ok;
  logic core_low;
  logic battery_ok;
  logic battery_low;
  logic battery_present;
  logic brownout_trip;
  logic supply_brownout_trip;
  logic power_evt;
  logic reset_evt;

  assign master_clear_b = s_q.sync2[0];
  assign core_ok = s_q.sync2[7];
  assign core_low = s_q.sync2[6];
  assign battery_ok = s_q.sync2[5];
  assign battery_low = s_q.sync2[4];
  assign battery_present = s_q.sync2[3];
  assign brownout_trip = s_q.sync2[2];
  assign supply_brownout_trip = s_q.sync2[1];

  // events that restart the full power sequence, and short-hold resets
  assign power_evt = s_q.core_mon.pulse | brownout_trip |
                     supply_brownout_trip | ~core_ok;
  assign reset_evt = core_ev.wdt_timeout | core_ev.config_mismatch |
                     core_ev.reset_instr | core_ev.stack_error;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;

    // two-stage synchroniser for every asynchronous input
    s_d.sync1 = {supply, master_clear_pin_b};
    s_d.sync2 = s_q.sync1;

    // read data stand for one cycle only; unmapped bits are zero
    s_d.rd_data = 8'h00;
    if (rd_en) begin
      case (addr)
        RCS_OFF_CAUSE: s_d.rd_data = s_q.reset_cause_control;
        RCS_OFF_CAUSE_TWO: s_d.rd_data = s_q.reset_cause_control_two;
        RCS_OFF_SUPPLY: s_d.rd_data = s_q.supply_reset_flags;
        RCS_OFF_SLEEP: s_d.rd_data = s_q.sleep_power_control;
        default: s_d.rd_data = 8'h00;
      endcase
    end

    // software writes: stores only, nothing here feeds the sequencer
    if (wr_en) begin
      case (addr)
        RCS_OFF_CAUSE: begin
          s_d.reset_cause_control = wr_merge(s_q.reset_cause_control,
            wr_data, RCS_CAUSE_WMASK, 8'h00);
        end
        RCS_OFF_CAUSE_TWO: begin
          s_d.reset_cause_control_two = wr_merge(
            s_q.reset_cause_control_two, wr_data,
            RCS_CAUSE_TWO_WMASK, RCS_CAUSE_TWO_CMASK);
        end
        RCS_OFF_SUPPLY: begin
          s_d.supply_reset_flags = wr_merge(s_q.supply_reset_flags,
            wr_data, RCS_SUPPLY_WMASK, RCS_SUPPLY_CMASK);
        end
        RCS_OFF_SLEEP: begin
          s_d.sleep_power_control = wr_merge(s_q.sleep_power_control,
            wr_data, RCS_SLEEP_WMASK, RCS_SLEEP_CMASK);
        end
        default: s_d = s_d;
      endcase
    end

    // retention select exists only while the retention config bit is 0
    if (retention_config_bit) begin
      s_d.sleep_power_control[RCS_RETENTION_SEL_BIT] = 1'b0;
    end

    // power-on monitors for core supply and battery pin
    s_d.core_mon = mon_step(s_q.core_mon, core_ok, core_low);
    s_d.battery_mon = mon_step(s_q.battery_mon, battery_ok,
                               battery_low);

    // hardware updates come after the write so an event in the same
    // cycle as a software write always wins
    if (s_q.core_mon.pulse) begin
      s_d.reset_cause_control[RCS_POWER_ON_BIT] = 1'b0;
      s_d.reset_cause_control[RCS_BROWNOUT_BIT] = 1'b0;
      s_d.reset_cause_control[RCS_WDT_TIMEOUT_BIT] = 1'b1;
      s_d.reset_cause_control[RCS_POWER_DOWN_BIT] = 1'b1;
      s_d.supply_reset_flags[RCS_SUPPLY_POWER_ON_BIT] = 1'b1;
      if (!s_q.first_power_on) begin
        s_d.supply_reset_flags[RCS_BATTERY_POWER_ON_BIT] = 1'b1;
      end
      s_d.first_power_on = 1'b1;
    end
    if (s_q.battery_mon.pulse) begin
      s_d.supply_reset_flags[RCS_BATTERY_POWER_ON_BIT] = 1'b1;
    end
    if (brownout_trip) begin
      s_d.reset_cause_control[RCS_BROWNOUT_BIT] = 1'b0;
    end
    if (supply_brownout_trip) begin
      s_d.supply_reset_flags[RCS_SUPPLY_BROWNOUT_BIT] = 1'b1;
    end
    if (!master_clear_b) begin
      s_d.reset_cause_control_two[RCS_MASTER_CLEAR_BIT] = 1'b1;
    end
    if (core_ev.config_mismatch) begin
      s_d.reset_cause_control[RCS_MISMATCH_BIT] = 1'b0;
    end
    if (core_ev.reset_instr) begin
      s_d.reset_cause_control[RCS_RESET_INSTR_BIT] = 1'b0;
    end

    // watchdog and power-down flags; a timeout beats a clear in one cycle
    if (core_ev.clear_watchdog_instruction) begin
      s_d.reset_cause_control[RCS_WDT_TIMEOUT_BIT] = 1'b1;
      s_d.reset_cause_control[RCS_POWER_DOWN_BIT] = 1'b1;
    end
    if (core_ev.sleep_instr) begin
      s_d.reset_cause_control[RCS_WDT_TIMEOUT_BIT] = 1'b1;
      s_d.reset_cause_control[RCS_POWER_DOWN_BIT] = 1'b0;
    end
    if (core_ev.wdt_timeout) begin
      s_d.reset_cause_control[RCS_WDT_TIMEOUT_BIT] = 1'b0;
    end
    if (core_ev.deep_sleep_wake) begin
      s_d.sleep_power_control[RCS_DEEP_SLEEP_WAKE_BIT] = 1'b1;
    end

    // most recent reset cause, one-hot
    if (s_q.core_mon.pulse) begin
      s_d.last_cause = 7'(1 << RCS_CAUSE_POWER_ON);
    end else if (brownout_trip | supply_brownout_trip) begin
      s_d.last_cause = 7'(1 << RCS_CAUSE_BROWNOUT);
    end else if (!master_clear_b) begin
      s_d.last_cause = 7'(1 << RCS_CAUSE_MASTER_CLEAR);
    end else if (core_ev.wdt_timeout) begin
      s_d.last_cause = 7'(1 << RCS_CAUSE_WATCHDOG);
    end else if (core_ev.config_mismatch) begin
      s_d.last_cause = 7'(1 << RCS_CAUSE_MISMATCH);
    end else if (core_ev.reset_instr) begin
      s_d.last_cause = 7'(1 << RCS_CAUSE_INSTR);
    end else if (core_ev.stack_error) begin
      s_d.last_cause = 7'(1 << RCS_CAUSE_STACK);
    end

    // sequencer: power events restart the whole chain, core resets
    // only hold reset briefly and are taken only while running
    if (power_evt) begin
      s_d.seq = RCS_SQ_BIAS;
      s_d.cnt = 16'h0000;
    end else if (reset_evt && (s_q.seq == RCS_SQ_RUN)) begin
      s_d.seq = RCS_SQ_HOLD;
      s_d.cnt = 16'h0000;
    end else begin
      case (s_q.seq)
        RCS_SQ_RUN: begin
          s_d.cnt = 16'h0000;
        end
        RCS_SQ_BIAS: begin
          if (cnt_done(s_q.cnt, RCS_BIAS_CYC)) begin
            s_d.seq = RCS_SQ_PWRT;
            s_d.cnt = 16'h0000;
          end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
          end
        end
        RCS_SQ_PWRT: begin
          if (cnt_done(s_q.cnt, PWRT_CYC)) begin
            s_d.seq = RCS_SQ_OSC;
            s_d.cnt = 16'h0000;
          end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
          end
        end
        RCS_SQ_OSC: begin
          if (cnt_done(s_q.cnt, RCS_OSC_CYC)) begin
            s_d.seq = RCS_SQ_RUN;
            s_d.cnt = 16'h0000;
            if (battery_present) begin
              s_d.supply_reset_flags[RCS_BATTERY_MODE_BIT] = 1'b1;
            end
          end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
          end
        end
        RCS_SQ_HOLD: begin
          if (cnt_done(s_q.cnt, RCS_HOLD_CYC)) begin
            s_d.seq = RCS_SQ_RUN;
            s_d.cnt = 16'h0000;
          end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
          end
        end
        default: begin
          s_d.seq = RCS_SQ_BIAS;
          s_d.cnt = 16'h0000;
        end
      endcase
    end

    // priority enable returns to 0 whenever the sequencer is out of the run state
    if (s_d.seq != RCS_SQ_RUN) begin
      s_d.reset_cause_control[RCS_IRQ_PRIO_BIT] = 1'b0;
    end

    // reset release needs a running sequencer and the pin high
    s_d.release_ok = (s_d.seq == RCS_SQ_RUN) & master_clear_b;

    // registered control outputs
    s_d.wdt_on = (watchdog_config_field == RCS_WDT_SW_MODE) &
                 s_d.reset_cause_control_two[RCS_SW_WDT_EN_BIT];
    s_d.retention_mode = s_d.sleep_power_control[RCS_RETENTION_SEL_BIT] &
                         ~retention_config_bit & regulator_en;
    // the bias bit governs only when retention is not in use
    s_d.pm_bias_on = ~s_d.retention_mode &
                     s_d.sleep_power_control[RCS_PM_SLEEP_BIAS_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= RCS_STATE_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system reset: the pin clears this flop with no clock so the core
  // stops at once; release waits for the synchronised pin and the
  // sequencer, so a short glitch cannot release early
  assign hold_b = rst_b & master_clear_pin_b;

  always_ff @(posedge clk or negedge hold_b) begin
    if (!hold_b) begin
      sys_reset_b_q <= 1'b0;
    end else if (ce) begin
      sys_reset_b_q <= s_q.release_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flop
  assign rd_data = s_q.rd_data;
  assign interrupt_priority_enable =
    s_q.reset_cause_control[RCS_IRQ_PRIO_BIT];
  assign watchdog_enable = s_q.wdt_on;
  assign retention_sleep_mode = s_q.retention_mode;
  assign pm_bias_sleep_on = s_q.pm_bias_on;
  assign system_reset_signal_b = sys_reset_b_q;
  assign core_hibernate = s_q.core_mon.hibernate;
  assign battery_hibernate = s_q.battery_mon.hibernate;
  assign reset_cause = s_q.last_cause;

endmodule : rcs_reset_cause

`default_nettype wire

// *** tb/rcs_reset_cause_properties.sv ***
// port-level assertions for the reset cause block
`timescale 1ns/1ps
`default_nettype none

module rcs_reset_cause_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  // pins and events
  input wire logic master_clear_pin_b,
  input wire rcs_pkg::rcs_supply_t supply,
  input wire rcs_pkg::rcs_core_ev_t core_ev,
  input wire logic [1:0] watchdog_config_field,
  input wire logic retention_config_bit,
  input wire logic regulator_en,
  // control outputs
  input wire logic interrupt_priority_enable,
  input wire logic watchdog_enable,
  input wire logic retention_sleep_mode,
  input wire logic pm_bias_sleep_on,
  input wire logic system_reset_signal_b,
  input wire logic core_hibernate,
  input wire logic [6:0] reset_cause
);
  import rcs_pkg::*;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // reset event seen while running, then a held core reset
  sequence s_hold_start;
    system_reset_signal_b && master_clear_pin_b &&
    (core_ev.wdt_timeout || core_ev.config_mismatch ||
     core_ev.reset_instr || core_ev.stack_error);
  endsequence
  sequence s_held;
    !system_reset_signal_b [*8];
  endsequence

  property p_rd_idle;
    !$past(rd_en) |-> rd_data == 8'h00;
  endproperty
  property p_interrupt_priority_enable_rise;
    $rose(interrupt_priority_enable) && $past(system_reset_signal_b, 3) |->
      $past(wr_en && addr == RCS_OFF_CAUSE && wr_data[7], 1) ||
      $past(wr_en && addr == RCS_OFF_CAUSE && wr_data[7], 2);
  endproperty
  property p_wdt_cfg;
    $past(watchdog_config_field) != RCS_WDT_SW_MODE |-> !watchdog_enable;
  endproperty
  property p_ret;
    $past(retention_config_bit) || !$past(regulator_en) |->
      !retention_sleep_mode;
  endproperty
  property p_bias;
    retention_sleep_mode |-> !pm_bias_sleep_on;
  endproperty
  property p_master_clear_pin_now;
    !master_clear_pin_b |-> !system_reset_signal_b;
  endproperty
  property p_master_clear_pin_cause;
    $fell(master_clear_pin_b) |-> ##[2:5] reset_cause == 7'h02;
  endproperty
  property p_event_hold;
    s_hold_start |-> ##[1:3] s_held;
  endproperty
  property p_por_hold;
    $rose(core_hibernate) |-> ##1 s_held;
  endproperty

  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_interrupt_priority_enable_rise: assert property (p_interrupt_priority_enable_rise) else $error("interrupt_priority_enable rose alone");
  a_wdt_cfg: assert property (p_wdt_cfg) else $error("watchdog on");
  a_ret: assert property (p_ret) else $error("retention wrongly on");
  a_bias: assert property (p_bias) else $error("bias with retention");
  a_master_clear_pin_now: assert property (p_master_clear_pin_now) else $error("pin not reset");
  a_master_clear_pin_cause: assert property (p_master_clear_pin_cause) else $error("no pin cause");
  a_event_hold: assert property (p_event_hold) else $error("no hold");
  a_por_hold: assert property (p_por_hold) else $error("no por hold");
endmodule : rcs_reset_cause_properties

bind rcs_reset_cause rcs_reset_cause_properties chk_u (.clk, .rst_b,
  .addr, .wr_data, .wr_en, .rd_en, .rd_data, .master_clear_pin_b, .supply,
  .core_ev, .watchdog_config_field, .retention_config_bit, .regulator_en,
  .interrupt_priority_enable, .watchdog_enable, .retention_sleep_mode,
  .pm_bias_sleep_on, .system_reset_signal_b, .core_hibernate, .reset_cause);
`default_nettype wire

// *** tb/tb_rcs_reset_cause.sv ***
// self-checking bench for the reset cause block
`timescale 1ns/1ps
`default_nettype none

module tb_rcs_reset_cause;
  import rcs_pkg::*;
  localparam int PW = 20;
  localparam int SEQ = RCS_BIAS_CYC + PW + RCS_OSC_CYC;
  localparam logic [7:0] WMASK [4] = '{RCS_CAUSE_WMASK, RCS_CAUSE_TWO_WMASK,
    RCS_SUPPLY_WMASK, RCS_SLEEP_WMASK};
  localparam logic [7:0] CMASK [4] = '{8'h00, RCS_CAUSE_TWO_CMASK,
    RCS_SUPPLY_CMASK, RCS_SLEEP_CMASK};
  logic clk, rst_b, ce, wr_en, rd_en, master_clear_pin_b;
  logic [1:0] addr, watchdog_config_field;
  logic [7:0] wr_data, rd_data, d;
  rcs_supply_t supply;
  rcs_core_ev_t core_ev;
  logic retention_config_bit, regulator_en, interrupt_priority_enable;
  logic watchdog_enable, retention_sleep_mode, pm_bias_sleep_on;
  logic system_reset_signal_b, core_hibernate, battery_hibernate;
  logic [6:0] reset_cause;
  logic [7:0] mdl [4];
  logic [1:0] a;
  int errors, check_count, n, k, seed;
  rcs_core_ev_t ev [4] = '{7'h40, 7'h20, 7'h10, 7'h08};
  logic [7:0] clr [4] = '{8'h08, 8'h20, 8'h10, 8'h00};
  logic [6:0] cs [4] = '{7'h04, 7'h08, 7'h20, 7'h40};

  rcs_reset_cause #(.PWRT_CYC(PW)) dut_u (.clk, .rst_b, .ce, .addr,
    .wr_data, .wr_en, .rd_en, .rd_data, .master_clear_pin_b, .supply,
    .core_ev, .watchdog_config_field, .retention_config_bit, .regulator_en,
    .interrupt_priority_enable, .watchdog_enable, .retention_sleep_mode,
    .pm_bias_sleep_on, .system_reset_signal_b, .core_hibernate,
    .battery_hibernate, .reset_cause);

  ////////////////////////////////////////////////////////////////////////////
  // clock and shared tasks
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // software register update: clear-only bits keep a written 1
  function automatic logic [7:0] upd(input logic [1:0] i, input logic [7:0] o,
                                     input logic [7:0] v);
    return (o & ~WMASK[i] & (~CMASK[i] | v)) | (v & WMASK[i]);
  endfunction : upd

  task automatic stop_test();
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // strobes drop after one edge; a gap edge keeps drives apart
  task automatic wr(input logic [1:0] i, input logic [7:0] v);
    addr <= i;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
    mdl[i] = upd(i, mdl[i], v);
  endtask : wr

  task automatic rd(input logic [1:0] i);
    addr <= i;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, mdl[i]);
    @(posedge clk);
  endtask : rd

  task automatic pulse(input rcs_core_ev_t e);
    core_ev <= e;
    @(posedge clk);
    core_ev <= '0;
    @(posedge clk);
  endtask : pulse

  // bounded wait for the core reset level
  task automatic wait_rst(input logic lvl, output int cnt);
    for (cnt = 0; cnt < 4000 && system_reset_signal_b !== lvl; cnt++)
      @(posedge clk);
    if (cnt >= 4000) begin
      errors++;
      stop_test();
    end
    #1;
  endtask : wait_rst

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'h9b81c72e;
    {rst_b, wr_en, rd_en, addr, wr_data, core_ev, supply} = '0;
    {watchdog_config_field, retention_config_bit, regulator_en} = '0;
    {ce, master_clear_pin_b, supply.core_ok} = 3'h7;
    errors = 0;
    check_count = 0;
    mdl = '{8'h3C, 8'h00, 8'h06, 8'h00};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    wait_rst(1'b1, n);
    chk({7'h0, n >= SEQ && n <= SEQ + 15}, 8'h01);
    chk({7'h0, core_hibernate}, 8'h01);
    for (k = 0; k < 4; k++)
      rd(2'(k));
    // reset events from the core, flags re-armed by software each time
    for (k = 0; k < 4; k++) begin
      wr(2'h0, 8'h33);
      pulse(ev[k]);
      wait_rst(1'b0, n);
      wait_rst(1'b1, n);
      mdl[0] = mdl[0] & ~clr[k];
      rd(2'h0);
      chk({1'b0, reset_cause}, {1'b0, cs[k]});
    end
    pulse(7'h02);
    mdl[0] = (mdl[0] | 8'h08) & ~8'h04;
    rd(2'h0);
    pulse(7'h04);
    mdl[0] = mdl[0] | 8'h0C;
    rd(2'h0);
    pulse(7'h01);
    mdl[3] = mdl[3] | 8'h04;
    rd(2'h3);
    // random register traffic with output checks
    repeat (40) begin
      a = 2'($random(seed));
      d = 8'($random(seed));
      watchdog_config_field <= 2'($random(seed));
      regulator_en <= 1'($random(seed));
      retention_config_bit <= 1'($random(seed));
      wr(a, d);
      if (retention_config_bit) mdl[3][4] = 1'b0;
      rd(a);
      chk({7'h0, watchdog_enable}, {7'h0, watchdog_config_field ==
        RCS_WDT_SW_MODE && mdl[1][5]});
      chk({7'h0, retention_sleep_mode}, {7'h0, mdl[3][4] & regulator_en});
      chk({7'h0, pm_bias_sleep_on}, {7'h0, mdl[3][0] &
        ~(mdl[3][4] & regulator_en)});
      chk({7'h0, interrupt_priority_enable}, {7'h0, mdl[0][7]});
      chk({7'h0, system_reset_signal_b}, 8'h01);
    end
    // a sleep pulse while the clock enable is low must change nothing
    ce <= 1'b0;
    pulse(7'h02);
    ce <= 1'b1;
    rd(2'h0);
    // master clear pin
    master_clear_pin_b <= 1'b0;
    @(posedge clk);
    #1 chk({7'h0, system_reset_signal_b}, 8'h00);
    repeat (5) @(posedge clk);
    master_clear_pin_b <= 1'b1;
    wait_rst(1'b1, n);
    mdl[1] = mdl[1] | 8'h80;
    rd(2'h1);
    chk({1'b0, reset_cause}, 8'h02);
    wr(2'h1, 8'h00);
    rd(2'h1);
    // brown-out trips
    wr(2'h0, 8'h33);
    wr(2'h2, 8'h00);
    supply.brownout_trip <= 1'b1;
    supply.supply_brownout_trip <= 1'b1;
    repeat (6) @(posedge clk);
    {supply.brownout_trip, supply.supply_brownout_trip} <= 2'h0;
    wait_rst(1'b1, n);
    mdl[0] = mdl[0] & ~8'h01;
    mdl[2] = mdl[2] | 8'h08;
    rd(2'h0);
    rd(2'h2);
    chk({1'b0, reset_cause}, 8'h10);
    // supply falls below start, rises again with battery present
    supply.core_ok <= 1'b0;
    supply.core_below_start <= 1'b1;
    repeat (6) @(posedge clk);
    chk({7'h0, core_hibernate}, 8'h00);
    {supply.core_below_start, supply.core_ok} <= 2'h1;
    supply.battery_present <= 1'b1;
    wait_rst(1'b1, n);
    mdl[0] = (mdl[0] & ~8'h03) | 8'h0C;
    mdl[2] = mdl[2] | 8'h05;
    rd(2'h0);
    rd(2'h2);
    chk({1'b0, reset_cause}, 8'h01);
    // backup battery monitor
    supply.battery_ok <= 1'b1;
    repeat (6) @(posedge clk);
    wait_rst(1'b1, n);
    mdl[2] = mdl[2] | 8'h02;
    rd(2'h2);
    chk({7'h0, battery_hibernate}, 8'h01);
    stop_test();
  end
endmodule : tb_rcs_reset_cause
`default_nettype wire
